// ### include/mpc_consts.vh
// Constants for the multifunction pin configuration decode
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH

// APB register byte addresses
`define MPC_ADDR_ATTN 12'h000
`define MPC_ADDR_THERM 12'h004
`define MPC_ADDR_STATUS 12'h008
`define MPC_ADDR_EVENT 12'h00C

// Reset values of the pin settings
`define MPC_ATTN_RESET 8'h00
`define MPC_THERM_RESET 8'h07

// Field positions inside a pin setting, as setting bit numbers
`define MPC_FXN_LSB 0
`define MPC_FXN_MSB 1
`define MPC_OPT_LSB 2
`define MPC_OPT_MSB 7
`define MPC_OPT_POL 7
`define MPC_OPT_HISUP 5
`define MPC_OPT_PU 4
`define MPC_OPT_DRVHI 3
`define MPC_OPT_PD 2

// Measurement fields of a pin setting in analog input function
`define MPC_MEAS_PU_MSB 7
`define MPC_MEAS_PU_LSB 6
`define MPC_MEAS_POLY_MSB 5
`define MPC_MEAS_POLY_LSB 4
`define MPC_MEAS_USE_MSB 3
`define MPC_MEAS_USE_LSB 2

// Pin function codes
`define MPC_FXN_SWIRE 2'h0
`define MPC_FXN_GPO 2'h1
`define MPC_FXN_ATTN 2'h2
`define MPC_FXN_MEAS 2'h3

// Polynomial code that reports raw counts
`define MPC_POLY_RAW 2'h3

`endif

// ### logic/mpc_meas_decode.v
// Measurement option decode for one pin set to analog input
`timescale 1ns/1ps
`include "mpc_consts.vh"

module mpc_meas_decode
(
    // Pin setting
    input wire [7:0] setting,
    // Decoded measurement controls
    output wire meas_en,
    output wire [1:0] pullup_sel,
    output wire [1:0] poly_sel,
    output wire raw_counts,
    output wire [1:0] use_sel
);

    // Option bits become measurement controls only in function 3
    assign meas_en = (setting[`MPC_FXN_MSB:`MPC_FXN_LSB] == `MPC_FXN_MEAS); // [RL8]
    assign pullup_sel = meas_en ? setting[`MPC_MEAS_PU_MSB:`MPC_MEAS_PU_LSB] : 2'h0; // [RL9]
    assign poly_sel = meas_en ? setting[`MPC_MEAS_POLY_MSB:`MPC_MEAS_POLY_LSB] : 2'h0; // [RL10]
    assign raw_counts = meas_en
        && (setting[`MPC_MEAS_POLY_MSB:`MPC_MEAS_POLY_LSB] == `MPC_POLY_RAW); // [RL10]
    assign use_sel = meas_en ? setting[`MPC_MEAS_USE_MSB:`MPC_MEAS_USE_LSB] : 2'h0; // [RL11]

endmodule // mpc_meas_decode

// ### logic/mpc_pin_config.v
// Configuration decode for the attention pin and the first thermistor pin
//
// Operation
// [RL1] Attention setting bits 1:0 pick single-wire, output, attention or analog input.
// [RL2] Option bit 5 sets attention polarity; ignored for general purpose output.
// [RL3] Option bit 3 picks high drive supply: 1.8 V rail or first regulator.
// [RL4] Option bit 2 enables weak pull-up to the first regulator output.
// [RL5] Software must not enable the pull-up while bit 3 picks regulator supply.
// [RL6] Option bit 1 clear floats the high state, set drives high.
// [RL7] Option bit 0 enables weak pull-down to ground.
// [RL8] Analog input function reinterprets all six option bits as measurement controls.
// [RL9] Option bits 5:4 pick 18k, 180k or no pull-up.
// [RL10] Option bits 3:2 pick 18K, 180K, custom model or raw counts.
// [RL11] Option bits 1:0 pick ADC, cell, report-only or FET thermistor use.
// [RL12] Attention setting resets to zero: single-wire or unused function.
// [RL13] Thermistor setting resets to 0x07: cell thermistor, 18k pull-up and model.
// [RL14] Thermistor function codes 0 to 2 leave it unused; 3 enables measurement.
// [RL15] Attention mode drives the asserted level while an attention event is pending.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "mpc_consts.vh"

module mpc_pin_config
(
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Internal attention event and output request
    input wire attn_pending,
    input wire gpo_level,
    // Attention pin drive controls
    output reg attn_pin_o,
    output reg attn_pin_oe,
    output reg attn_hi_sup_first_regulator_output,
    output reg attn_pullup_en,
    output reg attn_pulldown_en,
    output reg attn_swire_sel,
    // Attention pin measurement controls
    output reg attn_meas_en,
    output reg [1:0] attn_pullup_sel,
    output reg [1:0] attn_poly_sel,
    output reg attn_raw_counts,
    output reg [1:0] attn_use_sel,
    // First thermistor pin measurement controls
    output reg therm_meas_en,
    output reg [1:0] therm_pullup_sel,
    output reg [1:0] therm_poly_sel,
    output reg therm_raw_counts,
    output reg [1:0] therm_use_sel
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------

    reg [7:0] attn_cfg_q;
    reg [7:0] therm_cfg_q;
    reg hit_attn;
    reg hit_therm;
    reg hit_status;
    reg hit_event;
    wire setup_ph;
    wire wr_en;
    wire addr_ok;
    wire attn_wr;
    wire therm_wr;

    // Bus phases: the answer is prepared in setup, writes land in access
    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pwrite;

    // Word address decode; any other offset is unmapped
    always @*
    begin
        hit_attn = 1'b0;
        hit_therm = 1'b0;
        hit_status = 1'b0;
        hit_event = 1'b0;
        if (paddr == `MPC_ADDR_ATTN)
        begin
            hit_attn = 1'b1;
        end
        else if (paddr == `MPC_ADDR_THERM)
        begin
            hit_therm = 1'b1;
        end
        else if (paddr == `MPC_ADDR_STATUS)
        begin
            hit_status = 1'b1;
        end
        else if (paddr == `MPC_ADDR_EVENT)
        begin
            hit_event = 1'b1;
        end
    end

    // Status and event words are read-only; writes to them are dropped
    assign addr_ok = hit_attn || hit_therm || hit_status || hit_event;
    assign attn_wr = wr_en && hit_attn;
    assign therm_wr = wr_en && hit_therm;

    // Attention pin setting; bits 31:8 of the write word are ignored
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            attn_cfg_q <= `MPC_ATTN_RESET; // [RL12]
        end
        else if (attn_wr)
        begin
            attn_cfg_q <= pwdata[7:0];
        end
    end

    // First thermistor pin setting
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            therm_cfg_q <= `MPC_THERM_RESET; // [RL13]
        end
        else if (therm_wr)
        begin
            therm_cfg_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Decode of the attention pin setting
    // ----------------------------------------------------------------

    wire [1:0] attn_fxn;
    reg attn_is_swire;
    reg attn_is_gpo;
    reg attn_is_attn;
    wire attn_out_fn;
    reg attn_active;
    reg attn_level;
    reg attn_oe_d;

    assign attn_fxn = attn_cfg_q[`MPC_FXN_MSB:`MPC_FXN_LSB]; // [RL1]

    // One-hot view of the function field; code 3 goes to the analog decode
    always @*
    begin
        attn_is_swire = 1'b0;
        attn_is_gpo = 1'b0;
        attn_is_attn = 1'b0;
        case (attn_fxn)
            `MPC_FXN_SWIRE: attn_is_swire = 1'b1; // [RL1]
            `MPC_FXN_GPO: attn_is_gpo = 1'b1; // [RL1]
            `MPC_FXN_ATTN: attn_is_attn = 1'b1; // [RL1]
            default: attn_is_swire = 1'b0;
        endcase
    end

    // Both output functions share the drive options
    assign attn_out_fn = attn_is_gpo || attn_is_attn;

    // Logical high request: event after polarity, else the output level without polarity
    always @*
    begin
        attn_active = gpo_level;
        if (attn_is_attn)
        begin
            attn_active = attn_pending ^ attn_cfg_q[`MPC_OPT_POL]; // [RL2] [RL15]
        end
    end

    // In output functions drive low always; drive high only if bit 1 set or regulator supply chosen
    always @*
    begin
        attn_level = 1'b0;
        attn_oe_d = 1'b0;
        if (attn_out_fn)
        begin
            if (attn_active)
            begin
                attn_level = 1'b1;
                // Tristate high is unavailable with the regulator supply
                attn_oe_d = attn_cfg_q[`MPC_OPT_DRVHI] || attn_cfg_q[`MPC_OPT_HISUP]; // [RL6]
            end
            else
            begin
                attn_oe_d = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Measurement decode of both pins
    // ----------------------------------------------------------------

    wire a_meas_en;
    wire [1:0] a_pullup_sel;
    wire [1:0] a_poly_sel;
    wire a_raw;
    wire [1:0] a_use_sel;
    wire t_meas_en;
    wire [1:0] t_pullup_sel;
    wire [1:0] t_poly_sel;
    wire t_raw;
    wire [1:0] t_use_sel;

    // Attention pin in analog input function
    mpc_meas_decode u_attn_meas
    (
        .setting(attn_cfg_q),
        .meas_en(a_meas_en),
        .pullup_sel(a_pullup_sel),
        .poly_sel(a_poly_sel),
        .raw_counts(a_raw),
        .use_sel(a_use_sel)
    );

    // Thermistor pin: codes 0 to 2 leave it unused
    mpc_meas_decode u_therm_meas
    (
        .setting(therm_cfg_q),
        .meas_en(t_meas_en), // [RL14]
        .pullup_sel(t_pullup_sel),
        .poly_sel(t_poly_sel),
        .raw_counts(t_raw),
        .use_sel(t_use_sel)
    );

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------

    // Pin drive controls held in flip-flops; all zero outside output functions except attn_swire_sel, set in function 0
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            attn_pin_o <= 1'b0;
            attn_pin_oe <= 1'b0;
            attn_hi_sup_first_regulator_output <= 1'b0;
            attn_pullup_en <= 1'b0;
            attn_pulldown_en <= 1'b0;
            attn_swire_sel <= 1'b1;
        end
        else
        begin
            attn_pin_o <= attn_level; // [RL15]
            attn_pin_oe <= attn_oe_d; // [RL6]
            attn_hi_sup_first_regulator_output <= attn_out_fn && attn_cfg_q[`MPC_OPT_HISUP]; // [RL3]
            // Pull-up honoured even if software sets it with regulator supply
            attn_pullup_en <= attn_out_fn && attn_cfg_q[`MPC_OPT_PU]; // [RL4]
            attn_pulldown_en <= attn_out_fn && attn_cfg_q[`MPC_OPT_PD]; // [RL7]
            attn_swire_sel <= attn_is_swire; // [RL1]
        end
    end

    // Measurement controls of both pins held in flip-flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            attn_meas_en <= 1'b0;
            attn_pullup_sel <= 2'h0;
            attn_poly_sel <= 2'h0;
            attn_raw_counts <= 1'b0;
            attn_use_sel <= 2'h0;
            therm_meas_en <= 1'b0;
            therm_pullup_sel <= 2'h0;
            therm_poly_sel <= 2'h0;
            therm_raw_counts <= 1'b0;
            therm_use_sel <= 2'h0;
        end
        else
        begin
            attn_meas_en <= a_meas_en; // [RL8]
            attn_pullup_sel <= a_pullup_sel; // [RL9]
            attn_poly_sel <= a_poly_sel; // [RL10]
            attn_raw_counts <= a_raw;
            attn_use_sel <= a_use_sel; // [RL11]
            therm_meas_en <= t_meas_en; // [RL14]
            therm_pullup_sel <= t_pullup_sel;
            therm_poly_sel <= t_poly_sel;
            therm_raw_counts <= t_raw;
            therm_use_sel <= t_use_sel;
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------

    reg [31:0] rd_word;
    wire [31:0] status_word;
    wire [31:0] event_word;

    // Read-only views of the decode and of the two request inputs
    assign status_word = {26'h0, t_meas_en, a_meas_en, attn_pin_oe, attn_pin_o, attn_is_attn,
        attn_is_gpo};
    assign event_word = {30'h0, gpo_level, attn_pending};

    // Read multiplexer; unmapped offsets read as zero
    always @*
    begin
        rd_word = 32'h0000_0000;
        if (hit_attn)
        begin
            rd_word = {24'h0, attn_cfg_q};
        end
        else if (hit_therm)
        begin
            rd_word = {24'h0, therm_cfg_q};
        end
        else if (hit_status)
        begin
            rd_word = status_word;
        end
        else if (hit_event)
        begin
            rd_word = event_word;
        end
    end

    // Zero wait states: answer in the access cycle, pslverr for unmapped offsets
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_ok;
            prdata <= 32'h0000_0000;
            if (setup_ph && !pwrite)
            begin
                prdata <= rd_word;
            end
        end
    end

endmodule // mpc_pin_config

// ### tb/mpc_pin_config_monitor.sv
// Assertion checker for the pin configuration decode
`timescale 1ns/1ps
module mpc_pin_config_monitor
(
    // APB side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Attention pin controls
    input wire attn_pin_o,
    input wire attn_pin_oe,
    input wire attn_hi_sup_first_regulator_output,
    input wire attn_pullup_en,
    input wire attn_swire_sel,
    input wire attn_meas_en,
    input wire [1:0] attn_poly_sel,
    input wire attn_raw_counts,
    // Thermistor pin controls
    input wire therm_meas_en,
    input wire [1:0] therm_pullup_sel,
    input wire [1:0] therm_poly_sel,
    input wire therm_raw_counts,
    input wire [1:0] therm_use_sel
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus steps: setup, then an access that is answered
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    property p_answer;
        s_setup |=> s_answer;
    endproperty
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    property p_fxn_excl;
        !(attn_swire_sel && attn_meas_en);
    endproperty
    property p_meas_nodrv;
        attn_meas_en |-> !attn_pin_oe && !attn_pullup_en;
    endproperty
    property p_attn_raw;
        attn_raw_counts == (attn_meas_en && attn_poly_sel == 2'h3);
    endproperty
    property p_therm_raw;
        therm_raw_counts == (therm_meas_en && therm_poly_sel == 2'h3);
    endproperty
    property p_therm_off;
        !therm_meas_en |-> therm_pullup_sel == 2'h0 && therm_use_sel == 2'h0;
    endproperty
    property p_first_regulator_output_drive;
        !attn_swire_sel && !attn_meas_en && attn_hi_sup_first_regulator_output && attn_pin_o |-> attn_pin_oe;
    endproperty
    property p_defaults;
        $rose(presetn) |=> therm_meas_en && therm_use_sel == 2'h1 && attn_swire_sel;
    endproperty
    a_answer: assert property (p_answer) else $error("setup not answered");
    a_err: assert property (p_err) else $error("error flag out of place");
    a_fxn_excl: assert property (p_fxn_excl) else $error("two functions at once");
    a_meas_nodrv: assert property (p_meas_nodrv) else $error("analog pin driven");
    a_attn_raw: assert property (p_attn_raw) else $error("attn raw flag wrong");
    a_therm_raw: assert property (p_therm_raw) else $error("therm raw flag wrong");
    a_therm_off: assert property (p_therm_off) else $error("unused pin has controls");
    a_first_regulator_output_drive: assert property (p_first_regulator_output_drive) else $error("regulator high floats");
    a_defaults: assert property (p_defaults) else $error("reset defaults wrong");
endmodule // mpc_pin_config_monitor

bind mpc_pin_config mpc_pin_config_monitor mpc_pin_config_monitor_inst (.pclk, .presetn,
    .psel, .penable, .pready, .prdata, .pslverr, .attn_pin_o, .attn_pin_oe, .attn_hi_sup_first_regulator_output,
    .attn_pullup_en, .attn_swire_sel, .attn_meas_en, .attn_poly_sel, .attn_raw_counts,
    .therm_meas_en, .therm_pullup_sel, .therm_poly_sel, .therm_raw_counts, .therm_use_sel);

// ### tb/testbench.sv
// Self-checking bench for the pin configuration decode
`timescale 1ns/1ps
`include "mpc_consts.vh"
module testbench;
    // ----------------------------------------
    // Stimulus, design and helpers
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic attn_pending = 1'b0;
    logic gpo_level = 1'b0;
    wire pready, pslverr, attn_pin_o, attn_pin_oe, attn_hi_sup_first_regulator_output, attn_pullup_en;
    wire attn_pulldown_en, attn_swire_sel, attn_meas_en, attn_raw_counts;
    wire therm_meas_en, therm_raw_counts;
    wire [1:0] attn_pullup_sel, attn_poly_sel, attn_use_sel;
    wire [1:0] therm_pullup_sel, therm_poly_sel, therm_use_sel;
    wire [31:0] prdata;
    wire [31:0] attn_m = {24'h0, attn_meas_en, attn_pullup_sel, attn_poly_sel, attn_raw_counts,
        attn_use_sel};
    wire [31:0] therm_m = {24'h0, therm_meas_en, therm_pullup_sel, therm_poly_sel,
        therm_raw_counts, therm_use_sel};
    int error_cnt = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic er;
    mpc_pin_config mpc_pin_config_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .attn_pending, .gpo_level, .attn_pin_o,
        .attn_pin_oe, .attn_hi_sup_first_regulator_output, .attn_pullup_en, .attn_pulldown_en, .attn_swire_sel,
        .attn_meas_en, .attn_pullup_sel, .attn_poly_sel, .attn_raw_counts, .attn_use_sel,
        .therm_meas_en, .therm_pullup_sel, .therm_poly_sel, .therm_raw_counts, .therm_use_sel);
    // Clock of 100 ns period
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait2;
        repeat (2) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, `MPC_ADDR_ATTN, 32'h0);
        check("attn setting", 32'h0, rd);
        apb(1'b0, `MPC_ADDR_THERM, 32'h0);
        check("therm setting", 32'h07, rd);
        check("therm decode", 32'h81, therm_m);
        check("attn single wire", 32'h1, {31'h0, attn_swire_sel});
    endtask
    task automatic t_meas;
        logic [7:0] e;
        for (int o = 0; o < 64; o++)
        begin
            if (o[5:4] == 2'h3)
                continue;
            e = {1'b1, o[5:2], o[3:2] == 2'h3, o[1:0]};
            apb(1'b1, `MPC_ADDR_ATTN, {24'h0, o[5:0], 2'h3});
            apb(1'b1, `MPC_ADDR_THERM, {24'h0, o[5:0], 2'h3});
            wait2();
            check("attn meas", {24'h0, e}, attn_m);
            check("therm meas", {24'h0, e}, therm_m);
        end
        for (int f = 0; f < 3; f++)
        begin
            apb(1'b1, `MPC_ADDR_THERM, {24'h0, 6'h15, f[1:0]});
            wait2();
            check("therm unused", 32'h0, therm_m);
        end
    endtask
    task automatic t_outputs;
        logic [3:0] exp_drv;
        logic [3:0] drv_seen;
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, `MPC_ADDR_ATTN, {24'h0, p[1], 5'h02, `MPC_FXN_ATTN});
            attn_pending <= p[0];
            wait2();
            check("attn oe", 32'h1, {31'h0, attn_pin_oe});
            check("attn level", {31'h0, p[0] ^ p[1]}, {31'h0, attn_pin_o});
            apb(1'b0, `MPC_ADDR_EVENT, 32'h0);
            check("event word", {31'h0, p[0]}, rd);
            apb(1'b0, `MPC_ADDR_STATUS, 32'h0);
            check("status word", {26'h0, 3'h1, p[0] ^ p[1], 2'h2}, rd);
        end
        for (int o = 0; o < 32; o++)
        begin
            if (o[2] && o[3])
                continue;
            apb(1'b1, `MPC_ADDR_ATTN, {24'h0, 2'h2, o[3:0], `MPC_FXN_GPO});
            gpo_level <= o[4];
            wait2();
            exp_drv = {(o[4] ? (o[1] | o[3]) : 1'b1), o[3], o[2], o[0]};
            drv_seen = {attn_pin_oe, attn_hi_sup_first_regulator_output, attn_pullup_en, attn_pulldown_en};
            check("gpo drive", {28'h0, exp_drv}, {28'h0, drv_seen});
            check("gpo level", {31'h0, o[4]}, {31'h0, attn_pin_o});
        end
        apb(1'b1, `MPC_ADDR_ATTN, 32'hFC);
        wait2();
        check("function zero", 32'h2, {30'h0, attn_swire_sel, attn_meas_en});
    endtask
    task automatic t_bus;
        apb(1'b1, `MPC_ADDR_ATTN, 32'hFFFFFF41);
        apb(1'b1, 12'h010, 32'hFF);
        check("unmapped write error", 32'h1, {31'h0, er});
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped read data", 32'h0, rd);
        check("unmapped read error", 32'h1, {31'h0, er});
        apb(1'b0, `MPC_ADDR_ATTN, 32'h0);
        check("attn readback", 32'h41, rd);
        check("mapped read error", 32'h0, {31'h0, er});
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        #1000000;
        error_cnt++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_meas();
        t_outputs();
        t_bus();
        tally_and_finish();
    end
endmodule // testbench
